// ---- pkg/ivc_pkg.sv ----
// Shared constants, register layout and state codes for the control bank.
`default_nettype none
package ivc_pkg;
  // Register addresses carried in the register address byte.
  localparam logic [7:0] REG_OUTPUT_VOLTAGE_CODE      = 8'h00; // Output voltage code.
  localparam logic [7:0] REG_CTRL      = 8'h01; // Regulator control.
  // Default byte of the voltage register: parity 0, code 0110010.
  localparam logic [7:0] OUTPUT_VOLTAGE_CODE_RST      = 8'h32;
  // Control defaults: external mode, protection on, PWM, latch-off.
  localparam logic [7:0] CTRL_RST      = 8'h09;
  // Implemented control bits; the others read as zero.
  localparam logic [7:0] CTRL_MASK     = 8'h99;
  // Bit positions.
  localparam int         PAR_BIT       = 7;     // Stored parity bit.
  localparam int         CTRL_SEL_BIT  = 7;     // 1 = code drives target.
  localparam int         CTRL_PMSK_BIT = 4;     // 1 = blank protection.
  localparam int         CTRL_PWM_BIT  = 3;     // 1 = PWM at light load.
  localparam int         CTRL_LAT_BIT  = 0;     // 1 = latch-off mode.
  localparam int         CODE_W        = 7;     // Voltage code width.
  localparam logic [3:0] BYTE_BITS     = 4'h8;  // Bits per byte.
  localparam int         SYNC_W        = 11;    // Lines passing the syncs.
  // Link state machine, one-hot.
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,  // Waiting for START.
    ST_ADDR  = 9'h002,  // Shifting the device address byte.
    ST_ACKA  = 9'h004,  // Acknowledging the address.
    ST_REG   = 9'h008,  // Shifting the register address byte.
    ST_ACKR  = 9'h010,  // Acknowledging the register address.
    ST_WDAT  = 9'h020,  // Shifting the write data byte.
    ST_ACKW  = 9'h040,  // Acknowledging the data.
    ST_RDAT  = 9'h080,  // Sending the read byte.
    ST_RACK  = 9'h100   // Master acknowledge slot after a read.
  } ivc_state_t;
endpackage : ivc_pkg
`default_nettype wire

// ---- pkg/ivc_line_if.sv ----
// Synchronised link events and slow inputs passed to the register core.
`timescale 1ns/1ns
`default_nettype none
interface ivc_line_if;
  logic       scl_rise; // Clock line rose.
  logic       scl_fall; // Clock line fell.
  logic       start;    // START or repeated START seen.
  logic       stop;     // STOP seen.
  logic       sda;      // Synchronised data line level.
  logic       pwr_ok;   // Supply present and above lockout.
  logic       en;       // Enable input level.
  logic [6:0] ext_code; // Externally set voltage code.
  modport front (output scl_rise, scl_fall, start, stop, sda, pwr_ok, en,
                 ext_code);
  modport core  (input  scl_rise, scl_fall, start, stop, sda, pwr_ok, en,
                 ext_code);
endinterface : ivc_line_if
`default_nettype wire

// ---- hdl/ivc_line_sync.sv ----
// Two-stage synchronisers and bus condition detection for the link pins.
`timescale 1ns/1ns
`default_nettype none
module ivc_line_sync
  import ivc_pkg::*;
(
  input  wire logic              clk,   // Core clock.
  input  wire logic              rst_n, // Asynchronous reset, active low.
  input  wire logic [SYNC_W-1:0] raw,   // {ext code, en, pwr, sda, scl}.
  ivc_line_if.front              lines  // Events toward the core.
);
  logic [SYNC_W-1:0] s1_r; // First stage, read only by the second.
  logic [SYNC_W-1:0] s2_r; // Second stage, safe to use.
  logic [1:0]        s3_r; // Previous SCL/SDA for edge detection.

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser chain; idle bus lines reset high so no false edge appears.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= {{(SYNC_W-2){1'b0}}, 2'h3};
      s2_r <= {{(SYNC_W-2){1'b0}}, 2'h3};
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  // Delay stage for edge detection on the two link lines.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s3_r <= 2'h3;
    else
      s3_r <= s2_r[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conditions: START and STOP need SCL steady high across the SDA edge.
  assign lines.scl_rise = s2_r[0] & ~s3_r[0];
  assign lines.scl_fall = ~s2_r[0] & s3_r[0];
  assign lines.start    = s2_r[0] & s3_r[0] & ~s2_r[1] & s3_r[1];
  assign lines.stop     = s2_r[0] & s3_r[0] & s2_r[1] & ~s3_r[1];
  assign lines.sda      = s2_r[1];
  assign lines.pwr_ok   = s2_r[2];
  assign lines.en       = s2_r[3];
  // The external code is quasi-static; a change may tear for one cycle.
  assign lines.ext_code = s2_r[SYNC_W-1:4];
endmodule : ivc_line_sync
`default_nettype wire

// ---- hdl/ivc_i2c_regs.sv ----
// Serial target with the voltage code and regulator control registers.
//
// Overview of operation
// R1: Voltage code powers up as 0110010.
// R2: Select bit defaults external; 1 selects code.
// R3: Writing select 0 returns to external control.
// R4: Mask bit blanks protection on code changes.
// R5: Light-load bit: 0 PFM, 1 PWM, default 1.
// R6: Protection bit: 0 auto-recover, 1 latch, default 1.
// R7: Power loss, lockout or disable restores defaults.
// R8: Master sends XNOR of code bits as bit7.
// R9: Bad parity: no ACK, code unchanged.
// R10: Invalid control write leaves register unchanged.
// R11: Master should resend after a parity NACK.
// R12: Voltage read returns stored parity and code.
// R13: Foreign address ignored, no ACK, await START.
// R14: Valid data byte is ACKed and stored.
// R15: Read sends eight bits, idles after STOP.
// R16: New command acts within 27 clock periods.
// R17: Register address byte precedes each data byte.
`timescale 1ns/1ns
`default_nettype none
module ivc_i2c_regs
  import ivc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Target address, arbitrary value.
)
(
  input  wire logic                CORE_CLK,              // 50 MHz clock.
  input  wire logic                RST_N,                 // Async reset, low.
  input  wire logic                SCL_IN,                // Link clock pin.
  input  wire logic                SDA_IN,                // Data pin level.
  output logic                     SDA_OUT,               // Data drive value.
  output logic                     SDA_OE,                // High pulls low.
  input  wire logic                POWER_OK,              // Supply good.
  input  wire logic                ENABLE,                // Enable pin.
  input  wire logic [CODE_W-1:0]   EXT_VOLTAGE_CODE,      // External code.
  output logic [CODE_W-1:0]        OUTPUT_VOLTAGE_CODE,   // Stored code.
  output logic [CODE_W-1:0]        TARGET_VOLTAGE_CODE,   // Code in force.
  output logic                     VOLTAGE_FROM_CODE,     // Select bit.
  output logic                     PROT_MASK_ON_CHANGE,   // Mask bit.
  output logic                     PROT_BLANK,            // Protection off.
  output logic                     LIGHT_LOAD_PWM_SELECT, // Light-load mode.
  output logic                     PROT_LATCH_OFF         // Protection mode.
);
  ivc_line_if lines ();               // Synchronised events.
  ivc_state_t  state_r;               // Link state.
  logic [7:0]  shift_r;               // Received byte.
  logic [7:0]  tx_r;                  // Byte being sent.
  logic [3:0]  cnt_r;                 // Bits seen in this byte.
  logic        rw_r;                  // 1 = read transfer.
  logic        ptr_r;                 // Selected register.
  logic        sda_oe_r;              // Data line pulled low.
  logic [7:0]  output_voltage_code_r;                // Parity and voltage code.
  logic [7:0]  ctrl_r;                // Control register.
  logic [CODE_W-1:0] target_r;        // Code in force.
  logic        blank_r;               // Protection blanking pulse.
  logic        clear;                 // Restore defaults.
  logic        byte_done;             // Eighth bit ended on a falling edge.
  logic        addr_hit;              // Address byte names this target.
  logic        reg_ok;                // Register address is mapped.
  logic        par_ok;                // Parity bit matches the code.
  logic        wr_commit;             // Data byte accepted.

  ivc_line_sync u_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .raw   ({EXT_VOLTAGE_CODE, ENABLE, POWER_OK, SDA_IN, SCL_IN}),
    .lines (lines)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the byte just received.
  assign clear     = ~lines.pwr_ok | ~lines.en;                  // R7
  assign byte_done = lines.scl_fall & (cnt_r == BYTE_BITS);
  assign addr_hit  = (shift_r[7:1] == DEV_ADDR);                 // R13
  assign reg_ok    = (shift_r == REG_OUTPUT_VOLTAGE_CODE) | (shift_r == REG_CTRL); // R17
  // The master sends the XNOR of the code bits as the parity bit.
  assign par_ok    = (shift_r[PAR_BIT] == ~^shift_r[CODE_W-1:0]); // R8
  // Control writes have no check, so they are always valid.
  assign wr_commit = (state_r == ST_WDAT) & byte_done & (ptr_r | par_ok);

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine. START restarts from any state, STOP idles.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      state_r <= ST_IDLE;
    else if (clear)
      state_r <= ST_IDLE;
    else if (lines.start)
      state_r <= ST_ADDR;
    else if (lines.stop)
      state_r <= ST_IDLE;                                        // R15
    else if (lines.scl_fall)
    begin
      case (state_r)
        ST_ADDR:
          if (byte_done)
            state_r <= addr_hit ? ST_ACKA : ST_IDLE;             // R13
        ST_ACKA:
          state_r <= rw_r ? ST_RDAT : ST_REG;
        ST_REG:
          if (byte_done)
            state_r <= reg_ok ? ST_ACKR : ST_IDLE;               // R17
        ST_ACKR:
          state_r <= ST_WDAT;
        ST_WDAT:
          if (byte_done)
            state_r <= wr_commit ? ST_ACKW : ST_IDLE;            // R9
        ST_ACKW:
          state_r <= ST_IDLE;
        ST_RDAT:
          if (byte_done)
            state_r <= ST_RACK;
        ST_RACK:
          state_r <= ST_IDLE;                                    // R15
        ST_IDLE:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Bit counter and shifter; the acknowledge clock is never counted as data.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_r   <= 4'h0;
      shift_r <= 8'h00;
    end
    else if (lines.start || (lines.scl_fall && (cnt_r == BYTE_BITS ||
             state_r inside {ST_ACKA, ST_ACKR, ST_ACKW, ST_RACK})))
      cnt_r <= 4'h0;
    else if (lines.scl_rise)
    begin
      cnt_r   <= cnt_r + 4'h1;
      shift_r <= {shift_r[6:0], lines.sda};
    end
  end

  // Direction bit and register pointer; the pointer survives a restart.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rw_r  <= 1'b0;
      ptr_r <= 1'b0;
    end
    else if (state_r == ST_ADDR && byte_done)
      rw_r <= shift_r[0];
    else if (state_r == ST_REG && byte_done && reg_ok)
      ptr_r <= shift_r[0];                                       // R17
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive. Changes follow SCL falling edges so the master sees
  // stable data while SCL is high.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sda_oe_r <= 1'b0;
      tx_r     <= 8'h00;
    end
    else if (clear || lines.start || lines.stop)
      sda_oe_r <= 1'b0;
    else if (lines.scl_fall)
    begin
      case (state_r)
        ST_ADDR:
          sda_oe_r <= byte_done & addr_hit;                      // R13
        ST_REG:
          sda_oe_r <= byte_done & reg_ok;                        // R10
        ST_WDAT:
          sda_oe_r <= wr_commit;                                 // R14
        ST_ACKA:
          if (rw_r)
          begin
            // A voltage register read returns the stored parity with the code.
            tx_r     <= ptr_r ? (ctrl_r & CTRL_MASK) : output_voltage_code_r;  // R12
            sda_oe_r <= ptr_r ? ~ctrl_r[CTRL_SEL_BIT] : ~output_voltage_code_r[PAR_BIT];
          end
          else
            sda_oe_r <= 1'b0;
        ST_RDAT:
          if (byte_done)
            sda_oe_r <= 1'b0;                                    // R15
          else
          begin
            tx_r     <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        default:
          sda_oe_r <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage register. Accepted at the eighth falling edge of the data
  // byte, 26 clock periods after the start, inside the response limit.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      output_voltage_code_r <= OUTPUT_VOLTAGE_CODE_RST;                                        // R1
    else if (clear)
      output_voltage_code_r <= OUTPUT_VOLTAGE_CODE_RST;                                        // R7
    else if (wr_commit && !ptr_r)
      output_voltage_code_r <= shift_r;                                         // R16
  end

  // Control register; a clear write of the select bit always takes hold.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      ctrl_r <= CTRL_RST;                                        // R2
    else if (clear)
      ctrl_r <= CTRL_RST;                                        // R7
    else if (wr_commit && ptr_r)
      ctrl_r <= shift_r & CTRL_MASK;                             // R3
  end

  // Code in force, and blanking pulse when it moves with masking set.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      target_r <= OUTPUT_VOLTAGE_CODE_RST[CODE_W-1:0];
      blank_r  <= 1'b0;
    end
    else
    begin
      target_r <= ctrl_r[CTRL_SEL_BIT] ? output_voltage_code_r[CODE_W-1:0]
                                       : lines.ext_code;          // R2
      blank_r  <= ctrl_r[CTRL_PMSK_BIT] &
                  (target_r != (ctrl_r[CTRL_SEL_BIT] ?
                   output_voltage_code_r[CODE_W-1:0] : lines.ext_code));        // R4
    end
  end

  assign SDA_OUT               = 1'b0;
  assign SDA_OE                = sda_oe_r;
  assign OUTPUT_VOLTAGE_CODE   = output_voltage_code_r[CODE_W-1:0];
  assign TARGET_VOLTAGE_CODE   = target_r;
  assign VOLTAGE_FROM_CODE     = ctrl_r[CTRL_SEL_BIT];
  assign PROT_MASK_ON_CHANGE   = ctrl_r[CTRL_PMSK_BIT];
  assign PROT_BLANK            = blank_r;
  assign LIGHT_LOAD_PWM_SELECT = ctrl_r[CTRL_PWM_BIT];           // R5
  assign PROT_LATCH_OFF        = ctrl_r[CTRL_LAT_BIT];           // R6

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the design's own behaviour.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_data_end;
    (state_r == ST_WDAT) && byte_done && !lines.start && !lines.stop &&
    !clear;
  endsequence

  AST_OUTPUT_VOLTAGE_CODE_DEFAULT: assert property (clear |=> output_voltage_code_r == OUTPUT_VOLTAGE_CODE_RST) // R1
    else $error("voltage register not restored to default");
  AST_CTRL_DEFAULT: assert property (clear |=> ctrl_r == CTRL_RST) // R7
    else $error("control register not restored to default");
  AST_BAD_PARITY: assert property (s_data_end ##0 (!ptr_r && !par_ok)
    |=> $stable(output_voltage_code_r) && !sda_oe_r && state_r == ST_IDLE)       // R9
    else $error("bad parity byte changed code or was acked");
  AST_GOOD_WRITE: assert property (s_data_end ##0 (!ptr_r && par_ok)
    |=> output_voltage_code_r == $past(shift_r) && sda_oe_r)                     // R14
    else $error("valid voltage byte not stored and acked");
  AST_SEL_RETURN: assert property (s_data_end ##0 (ptr_r &&
    !shift_r[CTRL_SEL_BIT]) |=> !VOLTAGE_FROM_CODE ##1
    TARGET_VOLTAGE_CODE == $past(lines.ext_code))                 // R3
    else $error("select write of zero did not restore external control");
  AST_FOREIGN_ADDR: assert property ((state_r == ST_ADDR) && byte_done &&
    !addr_hit && !lines.start && !lines.stop && !clear
    |=> state_r == ST_IDLE && !sda_oe_r)                          // R13
    else $error("foreign address answered");
  AST_BAD_REG: assert property ((state_r == ST_REG) && byte_done &&
    !reg_ok && !lines.start && !lines.stop && !clear
    |=> ($stable(ctrl_r) && !sda_oe_r) [*2])                      // R10
    else $error("unmapped register address acked or changed control");
  AST_READ_FIRST: assert property ((state_r == ST_ACKA) && rw_r &&
    !ptr_r && lines.scl_fall && !lines.start && !lines.stop && !clear
    |=> sda_oe_r == ~output_voltage_code_r[PAR_BIT] && state_r == ST_RDAT)       // R12
    else $error("read does not start with stored parity bit");
  AST_READ_END: assert property ((state_r == ST_RACK) && lines.scl_fall &&
    !lines.start && !clear |=> state_r == ST_IDLE && !sda_oe_r)   // R15
    else $error("target did not release after read byte");
endmodule : ivc_i2c_regs
`default_nettype wire

// ---- tb/ivc_i2c_master.sv ----
// Behavioural bus master driving the link clock and the data line.
`timescale 1ns/1ns
`default_nettype none
module ivc_i2c_master
(
  input  wire logic clk,    // Core clock, used as the time base.
  output logic      scl,    // Link clock, stands high outside frames.
  output logic      sda_oe, // High pulls the data line low.
  input  wire logic sda     // Resolved data line level.
);
  // The bus idles released, so the pull-up shows a high level.
  initial
  begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Waits a number of core clock edges; 8 edges make one link period.
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // Data moves three cycles after the clock falls, keeping hold time.
  task automatic put_bit(input logic b);
    sda_oe <= ~b;
    w(1);
    scl <= 1'b1;
    w(4);
    scl <= 1'b0;
    w(3);
  endtask : put_bit
  // Samples three cycles into the four-cycle high phase, when the target's drive has settled.
  task automatic get_bit(output logic b);
    sda_oe <= 1'b0;
    w(1);
    scl <= 1'b1;
    w(3);
    b = sda;
    w(1);
    scl <= 1'b0;
    w(3);
  endtask : get_bit
  // Serves both as first and as repeated start.
  task automatic start_c();
    sda_oe <= 1'b0;
    w(1);
    scl <= 1'b1;
    w(4);
    sda_oe <= 1'b1;
    w(4);
    scl <= 1'b0;
    w(3);
  endtask : start_c
  // Leaves the bus idle, clock stopped high.
  task automatic stop_c();
    sda_oe <= 1'b1;
    w(1);
    scl <= 1'b1;
    w(4);
    sda_oe <= 1'b0;
    w(4);
  endtask : stop_c
  // Sends one byte, first bit most significant, and returns the ACK.
  task automatic wr_byte(input logic [7:0] d, output logic k);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    k = ~b;
  endtask : wr_byte
  // Takes one byte and answers with a NACK, ending the read.
  task automatic rd_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
  endtask : rd_byte
  // Whole write frame; ACKs come back as {address, register, data}.
  task automatic write_reg(input logic [6:0] dv, input logic [7:0] r,
                           input logic [7:0] d, output logic [2:0] a);
    start_c();
    wr_byte({dv, 1'b0}, a[2]);
    wr_byte(r, a[1]);
    wr_byte(d, a[0]);
    stop_c();
  endtask : write_reg
  // Pointer write, repeated start, then one byte read back.
  task automatic read_reg(input logic [6:0] dv, input logic [7:0] r,
                          output logic [7:0] d, output logic [2:0] a);
    start_c();
    wr_byte({dv, 1'b0}, a[2]);
    wr_byte(r, a[1]);
    start_c();
    wr_byte({dv, 1'b1}, a[0]);
    rd_byte(d);
    stop_c();
  endtask : read_reg
endmodule : ivc_i2c_master
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the voltage code and control register bank.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  import ivc_pkg::*;
  localparam logic [6:0] DEV = 7'h2A; // Target address, arbitrary value.
  // START lies 5 cycles into a frame, a link period is 8 cycles, and the
  // change watcher notes a new code one cycle late.
  localparam int RESP_CYC = 5 + 27 * 8 + 1;
  int         failures    = 0; // Mismatches seen.
  int         comparisons = 0; // Comparisons made.
  int         cyc         = 0; // Cycle count, also the hang limit.
  int         chg         = 0; // Cycle of the last stored code change.
  int         t0          = 0; // Cycle at which a write began.
  int         blanks      = 0; // Cycles with protection blanked.
  logic       clk         = 1'b0;
  logic       rst_n       = 1'b0;
  logic       pwr         = 1'b1;
  logic       en          = 1'b1;
  logic [6:0] ext         = 7'h11;
  logic       scl, m_oe, d_oe, d_out, sel, pmsk, blank, pwm, lat;
  logic [6:0] code, tgt, code_q;
  logic [7:0] v;
  logic [2:0] a;
  wire logic  sda;
  // Open-drain line with pull-up: low while either party drives a low.
  assign sda = (m_oe | (d_oe & ~d_out)) ? 1'b0 : 1'b1;
  always #10 clk = ~clk;
  ivc_i2c_master i_ivc_i2c_master (.clk(clk), .scl(scl), .sda_oe(m_oe),
                                   .sda(sda));
  ivc_i2c_regs #(.DEV_ADDR(DEV)) i_ivc_i2c_regs (
    .CORE_CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(d_out), .SDA_OE(d_oe), .POWER_OK(pwr), .ENABLE(en),
    .EXT_VOLTAGE_CODE(ext), .OUTPUT_VOLTAGE_CODE(code),
    .TARGET_VOLTAGE_CODE(tgt), .VOLTAGE_FROM_CODE(sel),
    .PROT_MASK_ON_CHANGE(pmsk), .PROT_BLANK(blank),
    .LIGHT_LOAD_PWM_SELECT(pwm), .PROT_LATCH_OFF(lat));
  ////////////////////////////////////////////////////////////////////////
  // Watches code changes and blanking, and cuts a hang short.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    code_q <= code;
    if (code_q !== code) chg <= cyc;
    if (blank === 1'b1) blanks <= blanks + 1;
    if (cyc == 40000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic wr(input logic [7:0] r, d);
    i_ivc_i2c_master.write_reg(DEV, r, d, a);
  endtask : wr
  task automatic rd(input logic [7:0] r);
    i_ivc_i2c_master.read_reg(DEV, r, v, a);
  endtask : rd
  // Every output but the blanking pulse and SDA_OE, and both registers, at their defaults.
  task automatic chk_dflt();
    `CHK(code, OUTPUT_VOLTAGE_CODE_RST[6:0])
    `CHK(d_out, 1'b0)
    `CHK(sel, 1'b0)
    `CHK(pmsk, 1'b0)
    `CHK(pwm, 1'b1)
    `CHK(lat, 1'b1)
    rd(REG_OUTPUT_VOLTAGE_CODE);
    `CHK(v, OUTPUT_VOLTAGE_CODE_RST)
    `CHK(a, 3'b111)
    rd(REG_CTRL);
    `CHK(v, CTRL_RST)
    `CHK(tgt, ext)
  endtask : chk_dflt
  ////////////////////////////////////////////////////////////////////////
  // A bad parity byte first, then the resend with good parity.
  task automatic t_codes();
    logic [6:0] tab [4];
    logic [6:0] c;
    logic       p;
    tab = '{7'h00, 7'h7F, 7'h55, 7'h33};
    for (int i = 0; i < 4; i++)
    begin
      c = tab[i];
      p = ~^c;
      wr(REG_OUTPUT_VOLTAGE_CODE, {~p, c});
      `CHK(a, 3'b110)
      `CHK(code, (i == 0) ? OUTPUT_VOLTAGE_CODE_RST[6:0] : tab[i-1])
      t0 = cyc;
      wr(REG_OUTPUT_VOLTAGE_CODE, {p, c});
      `CHK(a, 3'b111)
      `CHK(code, c)
      `CHK(chg > t0, 1'b1)
      `CHK((chg - t0) <= RESP_CYC, 1'b1)
      rd(REG_OUTPUT_VOLTAGE_CODE);
      `CHK(v, {p, c})
    end
  endtask : t_codes
  // Every implemented control bit set and cleared; others read zero.
  task automatic t_ctrl();
    logic [7:0] tab [2];
    tab = '{8'hFF, 8'h00};
    for (int i = 0; i < 2; i++)
    begin
      wr(REG_CTRL, tab[i]);
      `CHK(a, 3'b111)
      `CHK(sel, tab[i][7])
      `CHK(pmsk, tab[i][4])
      `CHK(pwm, tab[i][3])
      `CHK(lat, tab[i][0])
      rd(REG_CTRL);
      `CHK(v, tab[i] & CTRL_MASK)
      `CHK(tgt, tab[i][7] ? code : ext)
    end
  endtask : t_ctrl
  // Blanking follows the mask bit; clearing select hands back control.
  task automatic t_blank();
    wr(REG_CTRL, 8'h99);
    blanks = 0;
    wr(REG_OUTPUT_VOLTAGE_CODE, 8'h40);
    `CHK(blanks > 0, 1'b1)
    `CHK(tgt, 7'h40)
    wr(REG_CTRL, 8'h89);
    blanks = 0;
    wr(REG_OUTPUT_VOLTAGE_CODE, 8'hC1);
    `CHK(blanks, 0)
    `CHK(tgt, 7'h41)
    wr(REG_CTRL, 8'h09);
    `CHK(tgt, ext)
    @(posedge clk) ext <= 7'h5A;
    repeat (8) @(posedge clk);
    `CHK(tgt, 7'h5A)
  endtask : t_blank
  // Foreign address and unmapped register are both ignored.
  task automatic t_refuse();
    i_ivc_i2c_master.write_reg(DEV ^ 7'h01, REG_OUTPUT_VOLTAGE_CODE, 8'h80, a);
    `CHK(a, 3'b000)
    `CHK(code, 7'h41)
    wr(8'h05, 8'h00);
    `CHK(a, 3'b100)
    rd(REG_CTRL);
    `CHK(v, 8'h09)
    `CHK(a, 3'b111)
  endtask : t_refuse
  // Disable, then power loss, each restores the defaults.
  task automatic t_clear();
    for (int i = 0; i < 2; i++)
    begin
      wr(REG_CTRL, 8'h90);
      wr(REG_OUTPUT_VOLTAGE_CODE, 8'h40);
      @(posedge clk)
      begin
        en  <= (i != 0);
        pwr <= (i == 0);
      end
      repeat (6) @(posedge clk);
      en  <= 1'b1;
      pwr <= 1'b1;
      repeat (8) @(posedge clk);
      chk_dflt();
    end
  endtask : t_clear
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  // Reset for three cycles, settle the synchronisers, then the scenarios.
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk_dflt();
    t_codes();
    t_ctrl();
    t_blank();
    t_refuse();
    t_clear();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
